// >>> design/lmz_pkg.sv
/*
  Shared constants and carrier types of the LED scan and zero blanking block.
  Assumes a timebase tick that pulses once per oscillator cycle.
*/
`default_nettype none

package lmz_pkg;

  // Display geometry
  localparam int NUM_DIGITS = 8;
  localparam int BCD_W = 4;
  localparam int IDX_W = 3;

  // Nominal timebase in MHz, and its ratio to the low-frequency option
  localparam int OSC_MHZ_NOM = 10;
  localparam int LOW_OSC_DIV = 10;

  // Display timing in microseconds, measurement gap in milliseconds
  localparam int SLOT_US = 244;
  localparam int BLANK_US = 6;
  localparam int GAP_MS = 200;

  // Same times as timebase ticks at the nominal rate
  localparam int SLOT_TICKS = SLOT_US * OSC_MHZ_NOM;
  localparam int BLANK_TICKS = BLANK_US * OSC_MHZ_NOM;
  localparam int GAP_TICKS_NOM = GAP_MS * 1000 * OSC_MHZ_NOM;

  // Tick counter width, enough for the longest slot
  localparam int TICK_W = 12;

  // Digit two carries the decimal point on the shortest range
  localparam logic [2:0] DP_BASE_IDX = 3'h1;
  // Most significant digit, which also carries the overflow point
  localparam logic [2:0] TOP_IDX = 3'h7;

  // Reset values
  localparam logic [6:0] SEG_OFF = 7'h00;
  localparam logic [7:0] DIGITS_OFF = 8'h00;

  // Value to be shown, as presented by the counter latches
  typedef struct packed {
    logic [31:0] bcd;   // Eight BCD digits, digit one in the low nibble
    logic [1:0] range;  // Gate range, 0 is the shortest
    logic ovf;          // Main counter has overflowed
  } lmz_disp_t;

  // Pins toward the display
  typedef struct packed {
    logic [7:0] digit_en;  // Digit strobes, bit 0 is digit one
    logic [6:0] seg;       // Segments g..a
    logic dp;              // Decimal point segment
  } lmz_drive_t;

  // Scanner phases
  typedef enum logic {LMZ_GAP, LMZ_SHOW} lmz_state_t;

endpackage : lmz_pkg

`default_nettype wire

// >>> design/lmz_seg_dec.sv
/*
  BCD to seven-segment decoder for a common-cathode digit.
  Assumes segments ordered g..a with a high level lighting a segment.
*/
`default_nettype none

module lmz_seg_dec (
  // Digit in
  input wire logic [3:0] bcd,
  // Pattern out
  output logic [6:0] seg
);

  // Codes above nine light nothing rather than a bogus glyph
  always_comb
  begin
    case (bcd)
      4'h0: seg = 7'h3F;
      4'h1: seg = 7'h06;
      4'h2: seg = 7'h5B;
      4'h3: seg = 7'h4F;
      4'h4: seg = 7'h66;
      4'h5: seg = 7'h6D;
      4'h6: seg = 7'h7D;
      4'h7: seg = 7'h07;
      4'h8: seg = 7'h7F;
      4'h9: seg = 7'h6F;
      default: seg = lmz_pkg::SEG_OFF;
    endcase
  end

endmodule : lmz_seg_dec

`default_nettype wire

// >>> design/lmz_scan.sv
/*
  Digit scanner with interdigit blanking, leading zero blanking,
  overflow point and measurement gap pacing.
  Assumes osc_tick pulses one core_clk cycle per timebase cycle and that
  the value and range inputs are held steady by the counter latches.
*/
// What this block does
// - Scan digits, 244 us slot, 500 Hz
// - Everything off 6 us between slots
// - Blank leading zeros down to point digit
// - Digits right of point always shown
// - Overflow disables leading zero blanking
// - Scan and gap scale with timebase
// - Blanking rule fixed, no control input
// - Overflow lights point on top digit
// - Point on digit two plus range
// - Low timebase option divides by ten less
`default_nettype none

module lmz_scan #(
  parameter int GAP_TICKS = lmz_pkg::GAP_TICKS_NOM
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Timebase
  input wire logic osc_tick,
  input wire logic low_freq_sel,
  // Value from the latches
  input wire lmz_pkg::lmz_disp_t disp_i,
  // Display pins
  output lmz_pkg::lmz_drive_t drive_o,
  // Start of each measurement gap
  output logic meas_tick
);

  localparam int GAP_W = $clog2(GAP_TICKS + 1);

  // Refuse gaps too short to divide down
  if (GAP_TICKS < lmz_pkg::LOW_OSC_DIV)
  begin : g_chk
    $error("GAP_TICKS too small");
  end

  // Limit in ticks for a nominal count and the chosen timebase
  function automatic logic [31:0] tb_lim(input int full, input logic low);
    tb_lim = low ? 32'(full / lmz_pkg::LOW_OSC_DIV) : 32'(full);
  endfunction : tb_lim

  // Leading zero test, fixed with no way to alter it
  function automatic logic lead_zero(input logic [31:0] bcd,
                                     input logic [2:0] idx,
                                     input logic [2:0] dp_idx);
    logic zero;
    zero = (idx > dp_idx);
    for (int i = 0; i < lmz_pkg::NUM_DIGITS; i++)
    begin
      if (i >= int'(idx) && bcd[i*4 +: 4] != 4'h0)
      begin
        zero = 1'b0;
      end
    end
    lead_zero = zero;
  endfunction : lead_zero

  // Scanner state
  lmz_pkg::lmz_state_t state_q, state_d;
  logic [lmz_pkg::TICK_W-1:0] tick_q, tick_d;  // Ticks into this phase
  logic [2:0] idx_q, idx_d;                    // Digit being scanned
  // Registered pins
  lmz_pkg::lmz_drive_t drive_q, drive_d;
  // Measurement gap pacing
  logic [GAP_W-1:0] gap_q, gap_d;
  logic meas_q, meas_d;

  // Phase limits for the selected timebase
  logic [31:0] slot_lim, blank_lim, gap_lim;
  assign slot_lim = tb_lim(lmz_pkg::SLOT_TICKS, low_freq_sel);
  assign blank_lim = tb_lim(lmz_pkg::BLANK_TICKS, low_freq_sel);
  assign gap_lim = tb_lim(GAP_TICKS, low_freq_sel);

  // Current digit and its pattern
  logic [3:0] cur_bcd;
  logic [6:0] dec_seg;
  logic [2:0] dp_idx;
  logic blank_dig;
  logic phase_end;
  assign cur_bcd = disp_i.bcd[idx_q*4 +: 4];
  assign dp_idx = lmz_pkg::DP_BASE_IDX + {1'b0, disp_i.range};
  // Overflow shows every digit
  assign blank_dig = !disp_i.ovf &&
                     lead_zero(disp_i.bcd, idx_q, dp_idx);
  assign phase_end = osc_tick && (32'(tick_q) ==
    ((state_q == lmz_pkg::LMZ_SHOW) ? slot_lim : blank_lim) - 32'h1);

  lmz_seg_dec u_dec (
    .bcd(cur_bcd),
    .seg(dec_seg)
  );

  // Next phase, tick count and digit
  always_comb
  begin
    state_d = state_q;
    tick_d = tick_q;
    idx_d = idx_q;
    if (phase_end)
    begin
      tick_d = '0;
      if (state_q == lmz_pkg::LMZ_SHOW)
      begin
        state_d = lmz_pkg::LMZ_GAP;
      end
      else
      begin
        state_d = lmz_pkg::LMZ_SHOW;
        idx_d = idx_q + 3'h1;
      end
    end
    else if (osc_tick)
    begin
      tick_d = tick_q + 1'b1;
    end
  end

  // Pin values, one cycle ahead of the pins
  always_comb
  begin
    drive_d.digit_en = lmz_pkg::DIGITS_OFF;
    drive_d.seg = lmz_pkg::SEG_OFF;
    drive_d.dp = 1'b0;
    if (state_q == lmz_pkg::LMZ_SHOW)
    begin
      drive_d.digit_en = 8'h01 << idx_q;
      drive_d.seg = blank_dig ? lmz_pkg::SEG_OFF : dec_seg;
      drive_d.dp = (idx_q == dp_idx) ||
                   (disp_i.ovf && idx_q == lmz_pkg::TOP_IDX);
    end
  end

  // Gap pacing scales with the timebase like the scan
  always_comb
  begin
    gap_d = gap_q;
    meas_d = 1'b0;
    if (osc_tick)
    begin
      if (32'(gap_q) >= gap_lim - 32'h1)
      begin
        gap_d = '0;
        meas_d = 1'b1;
      end
      else
      begin
        gap_d = gap_q + 1'b1;
      end
    end
  end

  // Registers; first slot after reset is digit one
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= lmz_pkg::LMZ_GAP;
      tick_q <= '0;
      idx_q <= lmz_pkg::TOP_IDX;
      drive_q <= '0;
      gap_q <= '0;
      meas_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tick_q <= tick_d;
      idx_q <= idx_d;
      drive_q <= drive_d;
      gap_q <= gap_d;
      meas_q <= meas_d;
    end
  end

  assign drive_o = drive_q;
  assign meas_tick = meas_q;

  // Checks
  AST_ONE_STROBE: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW |=> $onehot(drive_q.digit_en))
    else $error("show slot without exactly one strobe");

  AST_GAP_DARK: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_GAP |=> drive_q == '0)
    else $error("pins lit during interdigit gap");

  AST_SLOT_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == lmz_pkg::LMZ_SHOW) ##1 (state_q == lmz_pkg::LMZ_GAP)
    |-> $past(osc_tick) && 32'($past(tick_q)) == slot_lim - 32'h1)
    else $error("slot ended at wrong tick");

  AST_BLANK_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == lmz_pkg::LMZ_GAP) ##1 (state_q == lmz_pkg::LMZ_SHOW)
    |-> 32'($past(tick_q)) == blank_lim - 32'h1)
    else $error("gap ended at wrong tick");

  AST_LEAD_BLANK: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW && !disp_i.ovf && idx_q > dp_idx &&
    (disp_i.bcd >> (idx_q * 4)) == 32'h0 |=> drive_q.seg == 7'h00)
    else $error("leading zero not blanked");

  AST_FRAC_SHOWN: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW && idx_q <= dp_idx
    |=> drive_q.seg == $past(dec_seg))
    else $error("digit right of point suppressed");

  AST_OVF_ALL: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW && disp_i.ovf
    |=> drive_q.seg == $past(dec_seg))
    else $error("blanking during overflow");

  AST_OVF_DP: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW && idx_q == 3'h7
    |=> drive_q.dp == ($past(disp_i.ovf) || $past(dp_idx) == 3'h7))
    else $error("overflow point wrong on top digit");

  AST_DP_POS: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW && idx_q == 3'h1 + {1'b0, disp_i.range}
    |=> drive_q.dp)
    else $error("decimal point missing");

  AST_GAP_PACE: assert property (@(posedge core_clk) disable iff (!rst_n)
    meas_q |-> $past(osc_tick)
    && 32'($past(gap_q)) >= $past(gap_lim) - 32'h1)
    else $error("measurement tick off pace");

  COV_SHOW: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW && idx_q == 3'h7);
  COV_BLANKED: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_q == lmz_pkg::LMZ_SHOW && blank_dig);
  COV_OVF: cover property (@(posedge core_clk) disable iff (!rst_n)
    drive_q.dp && drive_q.digit_en[7] && disp_i.ovf);
  COV_LOW: cover property (@(posedge core_clk) disable iff (!rst_n)
    meas_q && low_freq_sel);

endmodule : lmz_scan

`default_nettype wire

// >>> sim/lmz_disp_model.sv
/*
  Passive common-cathode display: keeps what each digit last showed.
  Assumes active-high strobes and segments, sampled on the scan clock.
*/
`default_nettype none

module lmz_disp_model (
  // Clock
  input wire logic core_clk,
  // Pins from the scanner
  input wire lmz_pkg::lmz_drive_t drive,
  // Last pattern per digit, point in bit 7 of each byte
  output logic [63:0] seen,
  // Count of overlapping strobes or ghost segments
  output int faults
);
  timeunit 1ns;
  timeprecision 1ps;

  initial seen = '0;
  initial faults = 0;

  // A lit digit latches its segments; dark segments must stay dark
  always @(posedge core_clk)
  begin
    if ($countones(drive.digit_en) > 1)
      faults <= faults + 1;
    else if (drive.digit_en == 8'h00 && {drive.seg, drive.dp} != 8'h00)
      faults <= faults + 1;
    for (int i = 0; i < 8; i++)
      if (drive.digit_en[i])
        seen[i*8 +: 8] <= {drive.dp, drive.seg};
  end
endmodule : lmz_disp_model

`default_nettype wire

// >>> sim/testbench.sv
/*
  Self-checking bench of the scanner: value table, then timing,
  timebase scaling, gap pacing and a reset in mid-run.
  Assumes the scanner and display model are compiled with it.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // Short gap so pacing checks stay brief
  localparam int GAP = 100;
  typedef struct {
    logic [31:0] bcd;
    logic [1:0] rng;
    logic ovf;
    int nblank;  // Leading digits expected dark
  } lmz_row_t;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_tick = 1'b0;
  logic low_freq_sel = 1'b1;
  // Stands for latches fed by inputs kept within their rate limits
  lmz_pkg::lmz_disp_t disp_i = '0;
  lmz_pkg::lmz_drive_t drive_o;
  logic meas_tick;
  logic [63:0] seen;
  logic [7:0] first;
  int faults, n, slot, gap, per, dv, lo;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int tick_div = 1;  // Core cycles per timebase tick
  int tick_cnt = 0;
  int mlow [3] = '{0, 1, 1};
  int mdiv [3] = '{1, 10, 4};
  logic [6:0] font [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D,
    7'h7D, 7'h07, 7'h7F, 7'h6F};
  lmz_row_t rows [6] = '{'{32'h00000123, 2'h0, 1'b0, 5},
    '{32'h00000000, 2'h0, 1'b0, 6}, '{32'h00000000, 2'h3, 1'b0, 3},
    '{32'h00000000, 2'h0, 1'b1, 0}, '{32'h19876045, 2'h1, 1'b0, 0},
    '{32'h00500000, 2'h2, 1'b0, 2}};

  lmz_scan #(.GAP_TICKS(GAP)) u_lmz_scan (.core_clk(core_clk),
    .rst_n(rst_n), .osc_tick(osc_tick), .low_freq_sel(low_freq_sel),
    .disp_i(disp_i), .drive_o(drive_o), .meas_tick(meas_tick));
  lmz_disp_model u_lmz_disp_model (.core_clk(core_clk), .drive(drive_o),
    .seen(seen), .faults(faults));

  // Clock of 5 ns
  always #2.5 core_clk = ~core_clk;

  // Timebase pulse every tick_div cycles, moved on the falling edge
  always @(negedge core_clk)
  begin
    tick_cnt <= (tick_cnt + 1) % tick_div;
    osc_tick <= (tick_cnt == 0);
  end

  // Hang guard, well above the expected run
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures = failures + 1;
      final_report();
    end
  end

  // Expected display bytes worked out from the blanking rules
  function automatic logic [63:0] exp_pat(lmz_row_t r);
    logic [63:0] p;
    p = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 8 - r.nblank)
        p[i*8 +: 7] = font[r.bcd[i*4 +: 4]];
      p[i*8+7] = (i == 1 + r.rng) || (i == 7 && r.ovf);
    end
    return p;
  endfunction : exp_pat

  task automatic check(string name, logic [63:0] e, logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : check

  // Cycles that the strobes hold value v
  task automatic run_len(logic [7:0] v, output int c);
    c = 0;
    while (drive_o.digit_en === v && c < 50000)
    begin
      c++;
      @(negedge core_clk);
    end
  endtask : run_len

  // Move on to the start of the next lit slot
  task automatic sync_slot();
    logic [7:0] v;
    int c;
    v = drive_o.digit_en;
    run_len(v, c);
    if (v != 8'h00)
      run_len(8'h00, c);
  endtask : sync_slot

  // Cycles between two gap pulses
  task automatic meas_period(output int p);
    while (meas_tick !== 1'b1)
      @(negedge core_clk);
    p = 0;
    do
    begin
      @(negedge core_clk);
      p++;
    end while (meas_tick !== 1'b1 && p < 50000);
  endtask : meas_period

  task automatic final_report();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Table of values, then timing per timebase mode, then reset
  initial
  begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      disp_i = '{bcd: rows[k].bcd, range: rows[k].rng, ovf: rows[k].ovf};
      // Two full scans of 244-tick slots and 6-tick gaps
      repeat (4000) @(negedge core_clk);
      check("pattern", exp_pat(rows[k]), seen);
    end
    // Codes above nine light nothing, even on a digit that is never blanked
    disp_i = '{bcd: 32'h0000001A, range: 2'h0, ovf: 1'b0};
    repeat (4000) @(negedge core_clk);
    check("bad_code", 64'h0000_0000_0000_8600, seen);
    // Mode switch at a slot start so no phase overruns
    for (int m = 0; m < 3; m++)
    begin
      sync_slot();
      low_freq_sel = mlow[m][0];
      tick_div = mdiv[m];
      dv = mdiv[m];
      lo = mlow[m] ? lmz_pkg::LOW_OSC_DIV : 1;
      sync_slot();
      first = drive_o.digit_en;
      run_len(first, slot);
      run_len(8'h00, gap);
      check("slot", lmz_pkg::SLOT_TICKS * dv / lo, slot);
      check("gap", lmz_pkg::BLANK_TICKS * dv / lo, gap);
      check("order", {first[6:0], first[7]}, drive_o.digit_en);
      meas_period(per);
      check("meas", GAP * dv / lo, per);
    end
    // Second reset in mid-run blanks everything
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    check("rst_drive", '0, {drive_o, meas_tick});
    rst_n = 1'b1;
    run_len(8'h00, n);
    check("first_digit", 8'h01, drive_o.digit_en);
    check("faults", 0, faults);
    final_report();
  end
endmodule : testbench

`default_nettype wire
